// [verilog/dsw_pkg.sv]
// constants shared by the data-space window and bank decoder
package dsw_pkg;

    localparam int          DATA_W          = 8;
    localparam int          PROG_W          = 12;
    localparam int          PAGE_W          = 6;
    localparam int          STACK_DEPTH     = 6;

    // data-space map
    localparam logic [7:0]  PAGE_LO         = 8'h00;
    localparam logic [7:0]  PAGE_HI         = 8'h3F;
    localparam logic [7:0]  WIN_LO          = 8'h40;
    localparam logic [7:0]  WIN_HI          = 8'h7F;
    localparam logic [7:0]  INT_OPT_ADDR    = 8'hC8;
    localparam logic [7:0]  WIN_BASE_ADDR   = 8'hC9;
    localparam logic [7:0]  BANK_SEL_ADDR   = 8'hE8;
    localparam logic [7:0]  EE_CTL_ADDR     = 8'hEA;

    // bank select field positions
    localparam int          RAM_PAGE2_BIT   = 4;
    localparam int          EE_PAGE1_BIT    = 1;
    localparam int          EE_PAGE0_BIT    = 0;

    // value returned by a read of a write-only location
    localparam logic [7:0]  WO_READ_VALUE   = 8'hFF;

    // values after reset
    localparam logic [7:0]  DATA_RESET      = 8'h00;
    localparam logic [11:0] PROG_RESET      = 12'h000;
    localparam logic [5:0]  PAGE_RESET      = 6'h00;

    // cycles from request to read data
    localparam int          READ_LATENCY    = 2;

    typedef enum logic [2:0]
    {
        DSW_NONE  = 3'b000,
        DSW_PAGE  = 3'b001,
        DSW_ROM   = 3'b010,
        DSW_WO    = 3'b011,
        DSW_EEPROM_CONTROL = 3'b100,
        DSW_REG   = 3'b101
    } dsw_kind_e;

endpackage

// [verilog/dsw_return_stack.sv]
// six-level 12-bit return-address stack
`timescale 1ns/1ps
`default_nettype none
module dsw_return_stack
    import dsw_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // push and pop
    input  wire logic              push,
    input  wire logic              pop,
    input  wire logic [PROG_W-1:0] pushAddr,
    output logic      [PROG_W-1:0] top_q
);

    logic [PROG_W-1:0] entry_q [STACK_DEPTH];
    logic [PROG_W-1:0] entry_d [STACK_DEPTH];

    // a push past six drops the oldest entry; a pop refills with zero
    genvar gi;
    generate
        for (gi = 0; gi < STACK_DEPTH; gi++)
        begin : g_entry
            always_comb
            begin
                entry_d[gi] = entry_q[gi];
                if (push)
                begin
                    entry_d[gi] = (gi == 0) ? pushAddr : entry_q[(gi == 0) ? 0 : gi - 1];
                end
                else if (pop)
                begin
                    entry_d[gi] = (gi == STACK_DEPTH - 1) ? PROG_RESET : entry_q[(gi == STACK_DEPTH - 1) ? gi : gi + 1];
                end
            end

            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    entry_q[gi] <= PROG_RESET;
                end
                else
                begin
                    entry_q[gi] <= entry_d[gi];
                end
            end
        end
    endgenerate

    assign top_q = entry_q[0];

endmodule
`default_nettype wire

// [verilog/dsw_decoder.sv]
// data-space decoder: read-only window, bank select, return stack
// What this block does
// - Six-entry, 12-bit return stack for calls, interrupts and current PC.
// - Reads at 40h-7Fh return program memory bytes, 64 at a time.
// - Program address is window base above the six low data address bits.
// - Only window base bits 5-0 count; bits 6 and 7 are ignored.
// - Window base at C9h takes whole-byte writes; software never reads it.
// - Reset leaves window base undefined; software loads it first.
// - Bank select at E8h is write-only; no reads or bit operations.
// - Bank select bit 4 maps RAM page 2; bits 7-5, 3-2 ignored.
// - Bits 1 and 0 map EEPROM pages 1 and 0, EEPROM variants only.
// - Paged bank uses addresses 00h-3Fh, bank chosen only by bank select.
// - Bank select is not cleared at reset; software writes it first.
// - Calls and interrupts leave bank select untouched, no save or restore.
// - EEPROM control at EAh lies outside paging, reachable in any bank.
// - Interrupt option register sits at C8h and is write-only.
// - Bank value 00 maps none, 01 EE page 0, 02 EE page 1, 10h RAM.
`timescale 1ns/1ps
`default_nettype none
module dsw_decoder
    import dsw_pkg::*;
#(
    parameter bit HasEeprom = 1'b1
)
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // core data bus
    input  wire logic [7:0]        dataAddr,
    input  wire logic              rdReq,
    input  wire logic              wrReq,
    input  wire logic [DATA_W-1:0] wrData,
    output logic      [DATA_W-1:0] rdData_q,
    output logic                   rdValid_q,
    // program memory
    output logic      [PROG_W-1:0] progAddr_q,
    output logic                   progRd_q,
    input  wire logic [DATA_W-1:0] progData,
    // paged ram and eeprom arrays
    output logic      [PAGE_W-1:0] pageAddr_q,
    output logic                   pageRd_q,
    output logic                   pageWr_q,
    output logic      [DATA_W-1:0] pageWrData_q,
    output logic                   ramPage2Sel_q,
    output logic                   eepromPage0Sel_q,
    output logic                   eepromPage1Sel_q,
    input  wire logic [DATA_W-1:0] pageData,
    // eeprom control and other registers
    output logic                   eepromCtlSel_q,
    output logic                   regSel_q,
    output logic      [7:0]        regAddr_q,
    output logic                   regWr_q,
    output logic      [DATA_W-1:0] regWrData_q,
    input  wire logic [DATA_W-1:0] regData,
    // interrupt option register
    output logic                   intOptWr_q,
    output logic      [DATA_W-1:0] intOptData_q,
    // return stack
    input  wire logic              stackPush,
    input  wire logic              stackPop,
    input  wire logic [PROG_W-1:0] pushAddr,
    output logic      [PROG_W-1:0] stackTop_q
);

    function automatic dsw_kind_e decodeKind(input logic [7:0] a);
        if (a <= PAGE_HI)
            return DSW_PAGE;
        else if (a >= WIN_LO && a <= WIN_HI)
            return DSW_ROM;
        else if (a == WIN_BASE_ADDR || a == BANK_SEL_ADDR || a == INT_OPT_ADDR)
            return DSW_WO;
        else if (a == EE_CTL_ADDR)
            return DSW_EEPROM_CONTROL;
        else
            return DSW_REG;
    endfunction

    dsw_kind_e   kindNow;
    logic        anyReq;
    logic [5:0]  winBase_q, winBase_d;
    logic [7:0]  bankSel_q, bankSel_d;
    dsw_kind_e   kind_q, kind_d;
    logic        rdPend_q, rdPend_d;
    logic [11:0] progAddr_d;
    logic [5:0]  pageAddr_d;
    logic        progRd_d, pageRd_d, pageWr_d, ram_d, ee0_d, ee1_d;
    logic        eeprom_control_d, regSel_d, regWr_d, intOptWr_d;
    logic [7:0]  pageWrData_d, regAddr_d, regWrData_d, intOptData_d, rdData_d;

    assign kindNow = decodeKind(dataAddr);
    assign anyReq  = rdReq | wrReq;

    // write-only registers: only whole-byte writes, kept bits only
    always_comb
    begin
        winBase_d = winBase_q;
        bankSel_d = bankSel_q;
        if (wrReq && dataAddr == WIN_BASE_ADDR)
            winBase_d = wrData[5:0];
        if (wrReq && dataAddr == BANK_SEL_ADDR)
        begin
            bankSel_d = DATA_RESET;
            bankSel_d[RAM_PAGE2_BIT] = wrData[RAM_PAGE2_BIT];
            bankSel_d[EE_PAGE1_BIT]  = wrData[EE_PAGE1_BIT];
            bankSel_d[EE_PAGE0_BIT]  = wrData[EE_PAGE0_BIT];
        end
    end

    // no reset on purpose: contents stay undefined until software loads them
    always_ff @(posedge ref_clk)
    begin
        winBase_q <= winBase_d;
        bankSel_q <= bankSel_d;
    end

    // access stage: route the request to its target
    always_comb
    begin
        kind_d       = anyReq ? kindNow : DSW_NONE;
        rdPend_d     = rdReq;
        progAddr_d   = progAddr_q;
        progRd_d     = 1'b0;
        pageAddr_d   = pageAddr_q;
        pageRd_d     = 1'b0;
        pageWr_d     = 1'b0;
        pageWrData_d = pageWrData_q;
        ram_d        = 1'b0;
        ee0_d        = 1'b0;
        ee1_d        = 1'b0;
        eeprom_control_d      = 1'b0;
        regSel_d     = 1'b0;
        regAddr_d    = regAddr_q;
        regWr_d      = 1'b0;
        regWrData_d  = regWrData_q;
        intOptWr_d   = 1'b0;
        intOptData_d = intOptData_q;
        case (kind_d)
            DSW_PAGE:
            begin
                pageAddr_d   = dataAddr[5:0];
                pageRd_d     = rdReq;
                pageWr_d     = wrReq;
                pageWrData_d = wrData;
                // several set bits drive several pages at once
                ram_d = bankSel_q[RAM_PAGE2_BIT];
                ee0_d = HasEeprom & bankSel_q[EE_PAGE0_BIT];
                ee1_d = HasEeprom & bankSel_q[EE_PAGE1_BIT];
            end
            DSW_ROM:
            begin
                progRd_d   = rdReq;
                progAddr_d = {winBase_q, dataAddr[5:0]};
            end
            DSW_WO:
            begin
                if (wrReq && dataAddr == INT_OPT_ADDR)
                begin
                    intOptWr_d   = 1'b1;
                    intOptData_d = wrData;
                end
            end
            DSW_EEPROM_CONTROL:
            begin
                eeprom_control_d     = 1'b1;
                regAddr_d   = dataAddr;
                regWr_d     = wrReq;
                regWrData_d = wrData;
            end
            DSW_REG:
            begin
                regSel_d    = 1'b1;
                regAddr_d   = dataAddr;
                regWr_d     = wrReq;
                regWrData_d = wrData;
            end
            default:
            begin
                regSel_d = 1'b0;
            end
        endcase
    end

    // return stage: pick the byte that came back
    always_comb
    begin
        case (kind_q)
            DSW_PAGE:  rdData_d = pageData;
            DSW_ROM:   rdData_d = progData;
            DSW_WO:    rdData_d = WO_READ_VALUE;
            DSW_EEPROM_CONTROL: rdData_d = regData;
            DSW_REG:   rdData_d = regData;
            default:   rdData_d = DATA_RESET;
        endcase
        if (!rdPend_q)
            rdData_d = rdData_q;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            kind_q           <= DSW_NONE;
            rdPend_q         <= 1'b0;
            progAddr_q       <= PROG_RESET;
            progRd_q         <= 1'b0;
            pageAddr_q       <= PAGE_RESET;
            pageRd_q         <= 1'b0;
            pageWr_q         <= 1'b0;
            pageWrData_q     <= DATA_RESET;
            ramPage2Sel_q    <= 1'b0;
            eepromPage0Sel_q <= 1'b0;
            eepromPage1Sel_q <= 1'b0;
            eepromCtlSel_q   <= 1'b0;
            regSel_q         <= 1'b0;
            regAddr_q        <= DATA_RESET;
            regWr_q          <= 1'b0;
            regWrData_q      <= DATA_RESET;
            intOptWr_q       <= 1'b0;
            intOptData_q     <= DATA_RESET;
            rdData_q         <= DATA_RESET;
            rdValid_q        <= 1'b0;
        end
        else
        begin
            kind_q           <= kind_d;
            rdPend_q         <= rdPend_d;
            progAddr_q       <= progAddr_d;
            progRd_q         <= progRd_d;
            pageAddr_q       <= pageAddr_d;
            pageRd_q         <= pageRd_d;
            pageWr_q         <= pageWr_d;
            pageWrData_q     <= pageWrData_d;
            ramPage2Sel_q    <= ram_d;
            eepromPage0Sel_q <= ee0_d;
            eepromPage1Sel_q <= ee1_d;
            eepromCtlSel_q   <= eeprom_control_d;
            regSel_q         <= regSel_d;
            regAddr_q        <= regAddr_d;
            regWr_q          <= regWr_d;
            regWrData_q      <= regWrData_d;
            intOptWr_q       <= intOptWr_d;
            intOptData_q     <= intOptData_d;
            rdData_q         <= rdData_d;
            rdValid_q        <= rdPend_q;
        end
    end

    dsw_return_stack u_stack
    (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .push     (stackPush),
        .pop      (stackPop),
        .pushAddr (pushAddr),
        .top_q    (stackTop_q)
    );

    // checks
    a_rom_addr_form: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdReq && dataAddr >= WIN_LO && dataAddr <= WIN_HI
        |=> progRd_q && progAddr_q == {$past(winBase_q), $past(dataAddr[5:0])})
        else $error("window program address wrong");

    a_rom_read_data: assert property (@(posedge ref_clk) disable iff (!rstn)
        progRd_q |=> rdValid_q && rdData_q == $past(progData))
        else $error("window read data not returned");

    a_base_write_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrReq && dataAddr == WIN_BASE_ADDR |=> winBase_q == $past(wrData[5:0]))
        else $error("window base not loaded");

    a_wo_read_junk: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdReq && !wrReq && (dataAddr == WIN_BASE_ADDR || dataAddr == BANK_SEL_ADDR)
        |-> ##1 (winBase_q == $past(winBase_q) && bankSel_q == $past(bankSel_q))
            ##1 (rdValid_q && rdData_q == WO_READ_VALUE))
        else $error("write-only read misbehaved");

    a_page_ram_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
        anyReq && dataAddr <= PAGE_HI
        |=> pageAddr_q == $past(dataAddr[5:0]) && ramPage2Sel_q == $past(bankSel_q[RAM_PAGE2_BIT]))
        else $error("ram page 2 select wrong");

    a_page_ee_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
        anyReq && dataAddr <= PAGE_HI
        |=> eepromPage0Sel_q == (HasEeprom && $past(bankSel_q[EE_PAGE0_BIT]))
            && eepromPage1Sel_q == (HasEeprom && $past(bankSel_q[EE_PAGE1_BIT])))
        else $error("eeprom page select wrong");

    a_no_bank_none: assert property (@(posedge ref_clk) disable iff (!rstn)
        bankSel_q == DATA_RESET |=> !ramPage2Sel_q && !eepromPage0Sel_q && !eepromPage1Sel_q)
        else $error("bank mapped with value zero");

    a_eeprom_control_unpaged: assert property (@(posedge ref_clk) disable iff (!rstn)
        anyReq && dataAddr == EE_CTL_ADDR
        |=> eepromCtlSel_q && !ramPage2Sel_q && !eepromPage0Sel_q && !eepromPage1Sel_q)
        else $error("eeprom control not reachable");

    a_intopt_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrReq && dataAddr == INT_OPT_ADDR |=> intOptWr_q && intOptData_q == $past(wrData))
        else $error("interrupt option write lost");

    a_stack_push: assert property (@(posedge ref_clk) disable iff (!rstn)
        stackPush ##1 stackPop && !stackPush |=> stackTop_q == $past(stackTop_q, 2))
        else $error("stack pop did not restore");

endmodule
`default_nettype wire

// [bench/dsw_far_model.sv]
// far-side model: program memory, paged arrays, register file
`timescale 1ns/1ps
`default_nettype none
module dsw_far_model
    import dsw_pkg::*;
(
    // clock
    input  wire logic              ref_clk,
    // program memory
    input  wire logic [PROG_W-1:0] progAddr_q,
    input  wire logic              progRd_q,
    output logic      [DATA_W-1:0] progData,
    // paged arrays
    input  wire logic [PAGE_W-1:0] pageAddr_q,
    input  wire logic              pageRd_q,
    input  wire logic              pageWr_q,
    input  wire logic [DATA_W-1:0] pageWrData_q,
    input  wire logic              ramPage2Sel_q,
    input  wire logic              eepromPage0Sel_q,
    input  wire logic              eepromPage1Sel_q,
    output logic      [DATA_W-1:0] pageData,
    // registers
    input  wire logic              eepromCtlSel_q,
    input  wire logic              regSel_q,
    input  wire logic [7:0]        regAddr_q,
    input  wire logic              regWr_q,
    input  wire logic [DATA_W-1:0] regWrData_q,
    output logic      [DATA_W-1:0] regData
);
    logic [DATA_W-1:0] pageMem [3][64];
    logic [DATA_W-1:0] regMem  [256];
    logic [DATA_W-1:0] junk;
    logic              anySel;
    int                pg;
    initial junk = 8'h5A;
    assign anySel = ramPage2Sel_q | eepromPage0Sel_q | eepromPage1Sel_q;
    assign pg = ramPage2Sel_q ? 2 : (eepromPage1Sel_q ? 1 : 0);
    // undriven cycles show a pattern that changes every clock
    always @(posedge ref_clk)
    begin
        junk <= {junk[6:0], ~junk[7]};
        if (pageWr_q && anySel)
            pageMem[pg][pageAddr_q] <= pageWrData_q;
        if (regWr_q)
            regMem[regAddr_q] <= regWrData_q;
    end
    assign progData = progRd_q ? (progAddr_q[7:0] ^ {2{progAddr_q[11:8]}}) : junk;
    assign pageData = (pageRd_q && anySel) ? pageMem[pg][pageAddr_q] : junk;
    assign regData  = (eepromCtlSel_q | regSel_q) ? regMem[regAddr_q] : junk;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// testbench for the data-space window and bank decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb_top;
    import dsw_pkg::*;
    logic              ref_clk, rstn, rdReq, wrReq, stackPush, stackPop;
    logic [7:0]        dataAddr, wrData;
    logic [PROG_W-1:0] pushAddr, pa;
    logic [7:0]        rdData_q, regAddr_q, regWrData_q, intOptData_q, progData, pageData, regData;
    logic [7:0]        pageWrData_q;
    logic              rdValid_q, progRd_q, pageRd_q, pageWr_q, ramPage2Sel_q, eepromPage0Sel_q;
    logic              eepromPage1Sel_q, eepromCtlSel_q, regSel_q, regWr_q, intOptWr_q;
    logic [PROG_W-1:0] progAddr_q, stackTop_q;
    logic [PAGE_W-1:0] pageAddr_q;
    int                errors, comparisons;
    logic [2:0]        pageSel, expSel;
    logic [7:0]        bases [3] = '{8'hE8, 8'h00, 8'hFF};
    logic [7:0]        addrs [3] = '{8'h59, 8'h40, 8'h7F};
    logic [7:0]        banks [3] = '{8'hF0, 8'h0D, 8'h02};
    logic [7:0]        vals  [3] = '{8'h5A, 8'h3C, 8'hC3};

    dsw_decoder dsw_decoder_inst (.ref_clk(ref_clk), .rstn(rstn), .dataAddr(dataAddr), .rdReq(rdReq),
        .wrReq(wrReq), .wrData(wrData), .rdData_q(rdData_q), .rdValid_q(rdValid_q), .progAddr_q(progAddr_q),
        .progRd_q(progRd_q), .progData(progData), .pageAddr_q(pageAddr_q), .pageRd_q(pageRd_q),
        .pageWr_q(pageWr_q), .pageWrData_q(pageWrData_q), .ramPage2Sel_q(ramPage2Sel_q),
        .eepromPage0Sel_q(eepromPage0Sel_q), .eepromPage1Sel_q(eepromPage1Sel_q), .pageData(pageData),
        .eepromCtlSel_q(eepromCtlSel_q), .regSel_q(regSel_q), .regAddr_q(regAddr_q), .regWr_q(regWr_q),
        .regWrData_q(regWrData_q), .regData(regData), .intOptWr_q(intOptWr_q), .intOptData_q(intOptData_q),
        .stackPush(stackPush), .stackPop(stackPop), .pushAddr(pushAddr), .stackTop_q(stackTop_q));
    dsw_far_model dsw_far_model_inst (.ref_clk(ref_clk), .progAddr_q(progAddr_q), .progRd_q(progRd_q),
        .progData(progData), .pageAddr_q(pageAddr_q), .pageRd_q(pageRd_q), .pageWr_q(pageWr_q),
        .pageWrData_q(pageWrData_q), .ramPage2Sel_q(ramPage2Sel_q), .eepromPage0Sel_q(eepromPage0Sel_q),
        .eepromPage1Sel_q(eepromPage1Sel_q), .pageData(pageData), .eepromCtlSel_q(eepromCtlSel_q),
        .regSel_q(regSel_q), .regAddr_q(regAddr_q), .regWr_q(regWr_q), .regWrData_q(regWrData_q),
        .regData(regData));
    assign pageSel = {ramPage2Sel_q, eepromPage1Sel_q, eepromPage0Sel_q};

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // whole-byte writes only, never single-bit operations
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        dataAddr = a;
        wrData = d;
        wrReq = 1'b1;
        @(negedge ref_clk);
        wrReq = 1'b0;
    endtask

    // valid pulse stands only in the cycle after the target strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        dataAddr = a;
        rdReq = 1'b1;
        @(negedge ref_clk);
        rdReq = 1'b0;
        @(negedge ref_clk);
        `CHK(rdValid_q, 1'b1)
        `CHK(rdData_q, e)
    endtask

    task automatic stk(input logic push, input logic [PROG_W-1:0] a, input logic [PROG_W-1:0] e);
        @(negedge ref_clk);
        stackPush = push;
        stackPop = ~push;
        pushAddr = a;
        @(negedge ref_clk);
        stackPush = 1'b0;
        stackPop = 1'b0;
        `CHK(stackTop_q, e)
    endtask

    initial
    begin
        #100us;
        errors++;
        final_report();
    end

    initial
    begin
        {rstn, rdReq, wrReq, stackPush, stackPop} = '0;
        dataAddr = 8'h00;
        wrData = 8'h00;
        pushAddr = 12'h000;
        expSel = 3'b000;
        repeat (3) @(posedge ref_clk);
        `CHK(stackTop_q, 12'h000)
        `CHK(rdValid_q, 1'b0)
        @(negedge ref_clk);
        rstn = 1'b1;
        $display("test reset done");
        // base written before the first window read; its ram copy goes first
        foreach (bases[i])
        begin
            wr(8'h84, bases[i]);
            wr(WIN_BASE_ADDR, bases[i]);
            rd_chk(8'h84, bases[i]);
            foreach (addrs[j])
            begin
                pa = {bases[i][5:0], addrs[j][5:0]};
                rd_chk(addrs[j], pa[7:0] ^ {2{pa[11:8]}});
                `CHK(progAddr_q, pa)
            end
        end
        $display("test window done");
        // one mapped bit per value; the others are ignored bits
        foreach (banks[i])
        begin
            wr(BANK_SEL_ADDR, banks[i]);
            wr(8'h3F, vals[i]);
            expSel = {banks[i][RAM_PAGE2_BIT], banks[i][EE_PAGE1_BIT], banks[i][EE_PAGE0_BIT]};
            `CHK(pageSel, expSel)
        end
        // value zero maps no page, so this write must land nowhere
        wr(BANK_SEL_ADDR, 8'h00);
        wr(8'h3F, 8'hEE);
        `CHK(pageWr_q, 1'b1)
        `CHK(pageSel, 3'b000)
        foreach (banks[i])
        begin
            wr(BANK_SEL_ADDR, banks[i]);
            stk(1'b1, 12'h0AA, 12'h0AA);
            stk(1'b0, 12'h000, 12'h000);
            rd_chk(8'h3F, vals[i]);
            `CHK(pageAddr_q, 6'h3F)
        end
        $display("test banks done");
        rd_chk(WIN_BASE_ADDR, WO_READ_VALUE);
        rd_chk(BANK_SEL_ADDR, WO_READ_VALUE);
        rd_chk(INT_OPT_ADDR, WO_READ_VALUE);
        rd_chk(8'h3F, vals[2]);
        pa = {6'h3F, 6'h00};
        rd_chk(8'h40, pa[7:0] ^ {2{pa[11:8]}});
        $display("test write-only done");
        wr(EE_CTL_ADDR, 8'h41);
        wr(BANK_SEL_ADDR, 8'h10);
        rd_chk(EE_CTL_ADDR, 8'h41);
        `CHK(regAddr_q, EE_CTL_ADDR)
        wr(INT_OPT_ADDR, 8'h9C);
        `CHK(intOptWr_q, 1'b1)
        `CHK(intOptData_q, 8'h9C)
        $display("test registers done");
        for (int k = 1; k <= 7; k++)
            stk(1'b1, 12'h100 + 12'(k), 12'h100 + 12'(k));
        for (int k = 1; k <= 5; k++)
            stk(1'b0, 12'h000, 12'h107 - 12'(k));
        // push and pop on adjacent edges must give back the old top
        @(negedge ref_clk);
        stackPush = 1'b1;
        pushAddr = 12'h0C3;
        @(negedge ref_clk);
        `CHK(stackTop_q, 12'h0C3)
        stackPush = 1'b0;
        stackPop = 1'b1;
        @(negedge ref_clk);
        stackPop = 1'b0;
        `CHK(stackTop_q, 12'h102)
        stk(1'b0, 12'h000, 12'h000);
        $display("test stack done");
        final_report();
    end
endmodule
`default_nettype wire
